// File: ibc_channel_setup.sv
// Register file, scan sequencer and button decision of the inductive button channels
//
// Behaviour
// - Power pin high normal, low low-power
// - One enable bit per channel
// - Separate output and interrupt polarity registers
// - Eight halving scan rates, two rate registers
// - Window is 128*(cycles+1)*2^divider sensor periods
// - Six-bit gain level per channel
// - Detection threshold resets to 160
// - Pause/max-win, twist, common/deform feature registers
// - Per-channel sensor setup at every second address
// - Interrupt on press or error, default low
`timescale 1ns/1ps
module ibc_channel_setup import ibc_pkg::*; #(
  parameter int SCAN_BASE_CYCLES = SCAN_BASE_CYCLES_DEF,
  parameter int SENSOR_TICK_CYCLES = 1,
  parameter int RESULT_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Power mode strap
  input wire logic power_mode_select_pin,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Conversion front end
  input wire logic [NCH-1:0][RESULT_W-1:0] channel_result,
  input wire logic front_error,
  output logic sample_active,
  output logic [1:0] sample_channel,
  output logic [2:0] sensor_freq_sel,
  output logic [5:0] channel_gain_level,
  // Post-processing controls
  output logic [NCH-1:0] baseline_pause,
  output logic [NCH-1:0] common_mode_en,
  output logic [NCH-1:0] deform_en,
  // Pins
  output logic [NCH-1:0] button_output_pin,
  output logic interrupt_pin
);

  if (SCAN_BASE_CYCLES < 1 || SCAN_BASE_CYCLES * (2 ** (RATE_STEPS - 1)) >= 2 ** SCAN_W)
    $error("SCAN_BASE_CYCLES out of range");
  if (SENSOR_TICK_CYCLES < 1 || SENSOR_TICK_CYCLES > 8)
    $error("SENSOR_TICK_CYCLES out of range");
  if (RESULT_W < 9 || RESULT_W > 24)
    $error("RESULT_W out of range");

  // ----------------------------------------
  // Decoding functions
  // ----------------------------------------
  function automatic logic [IXW-1:0] reg_index(input logic [7:0] a);
    reg_index = IXW'(NREG);
    for (int k = 0; k < NREG; k++) begin
      if (REG_OFF[k] == a) begin
        reg_index = IXW'(k);
      end
    end
  endfunction

  // Longest window is 8*128*16*128 cycles, well inside WIN_W
  function automatic logic [WIN_W-1:0] win_len(input logic [3:0] cyc, input logic [2:0] dv);
    win_len = (WIN_W'(SENSOR_TICK_CYCLES) * WIN_W'(WINDOW_UNIT) * (WIN_W'(cyc) + 1'b1)) << dv;
  endfunction

  function automatic logic [NCH-1:0] max_pick(input logic [NCH-1:0] cand,
                                               input logic [NCH-1:0][RESULT_W-1:0] v);
    logic signed [RESULT_W-1:0] best;
    logic found;
    max_pick = '0;
    best = '0;
    found = 1'b0;
    for (int k = 0; k < NCH; k++) begin
      if (cand[k] && (!found || $signed(v[k]) > best)) begin
        best = $signed(v[k]);
        max_pick = '0;
        max_pick[k] = 1'b1;
        found = 1'b1;
      end
    end
  endfunction

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [7:0] regs_reg [NREG];
  ibc_cfg_type cfg_reg, cfg_next;
  ibc_state_type state_reg;
  logic low_power_reg;
  logic [SCAN_W-1:0] scan_cnt_reg;
  logic [WIN_W-1:0] win_cnt_reg;
  logic [1:0] ch_reg;
  logic [NCH-1:0][RESULT_W-1:0] res_reg;
  logic [NCH-1:0] press_reg;

  // ----------------------------------------
  // Register port decode
  // ----------------------------------------
  wire [IXW-1:0] addr_ix = reg_index(reg_addr);
  wire addr_hit = addr_ix != IXW'(NREG);
  wire wr_ok = reg_wr && addr_hit && addr_ix != IXW'(IX_STATUS);
  wire scanning = state_reg != ST_WAIT;
  wire [7:0] status_val = {low_power_reg, 2'b00, scanning, press_reg};
  wire [7:0] rd_val = !addr_hit ? 8'h00 :
                      addr_ix == IXW'(IX_STATUS) ? status_val : regs_reg[addr_ix];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < NREG; k++) begin
        regs_reg[k] <= (k == IX_THRESHOLD) ? THRESHOLD_RESET : REG_RESET;
      end
    end else if (wr_ok) begin
      regs_reg[addr_ix] <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_val : 8'h00;
      reg_rvalid <= reg_rd;
    end
  end

  // ----------------------------------------
  // Snapshot taken at scan start
  // ----------------------------------------
  // Host writes land in regs_reg at once; the sequencer sees this copy, but scan_period takes the rate from cfg_next live
  always_comb begin
    cfg_next.enable = regs_reg[IX_ENABLE][NCH-1:0];
    cfg_next.rate = low_power_reg ? regs_reg[IX_LP_RATE][2:0] : regs_reg[IX_NP_RATE][2:0];
    cfg_next.pause = regs_reg[IX_PAUSE_WIN][NCH-1:0];
    cfg_next.maxwin = regs_reg[IX_PAUSE_WIN][HIGH_NIBBLE +: NCH];
    cfg_next.twist = regs_reg[IX_TWIST][0];
    cfg_next.common = regs_reg[IX_COMMON_DEF][NCH-1:0];
    cfg_next.deform = regs_reg[IX_COMMON_DEF][HIGH_NIBBLE +: NCH];
    cfg_next.out_pol = regs_reg[IX_OUT_POL][NCH-1:0];
    cfg_next.int_pol = regs_reg[IX_INTERRUPT_POLARITY][0];
    cfg_next.divider = regs_reg[IX_DIVIDER][2:0];
    cfg_next.threshold = regs_reg[IX_THRESHOLD];
    for (int k = 0; k < NCH; k++) begin
      cfg_next.cycles[k] = regs_reg[IX_SENS0 + k][SENS_CYC_LSB +: 4];
      cfg_next.freq[k] = regs_reg[IX_SENS0 + k][SENS_FREQ_LSB +: 3];
      cfg_next.gain[k] = regs_reg[GAIN_IX[k]][5:0];
    end
  end

  // ----------------------------------------
  // Scan sequencer
  // ----------------------------------------
  wire scan_tick = scan_cnt_reg == '0;
  wire scan_start = state_reg == ST_WAIT && scan_tick;
  wire [SCAN_W-1:0] scan_period = SCAN_W'(SCAN_BASE_CYCLES) << cfg_next.rate;
  wire ch_on = cfg_reg.enable[ch_reg];
  wire [WIN_W-1:0] ch_win = win_len(cfg_reg.cycles[ch_reg], cfg_reg.divider);
  wire win_done = state_reg == ST_SAMPLE && win_cnt_reg == '0;
  wire last_ch = ch_reg == 2'(NCH - 1);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_power_reg <= 1'b0;
    end else begin
      low_power_reg <= !power_mode_select_pin;
    end
  end

  // Ticks that fall while a scan runs are dropped: a window longer than the
  // scan period stretches the period instead of overlapping scans
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_cnt_reg <= '0;
    end else begin
      scan_cnt_reg <= scan_tick ? scan_period - 1'b1 : scan_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_WAIT;
      ch_reg <= 2'd0;
      win_cnt_reg <= '0;
      cfg_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_WAIT: begin
          if (scan_start) begin
            cfg_reg <= cfg_next;
            ch_reg <= 2'd0;
            state_reg <= ST_SEL;
          end
        end
        ST_SEL: begin
          if (ch_on) begin
            win_cnt_reg <= ch_win - 1'b1;
            state_reg <= ST_SAMPLE;
          end else if (last_ch) begin
            state_reg <= ST_DECIDE;
          end else begin
            ch_reg <= ch_reg + 2'd1;
          end
        end
        ST_SAMPLE: begin
          if (win_done) begin
            state_reg <= last_ch ? ST_DECIDE : ST_SEL;
            ch_reg <= last_ch ? ch_reg : ch_reg + 2'd1;
          end else begin
            win_cnt_reg <= win_cnt_reg - 1'b1;
          end
        end
        ST_DECIDE: begin
          state_reg <= ST_WAIT;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Front-end drive and result capture
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_active <= 1'b0;
      sample_channel <= 2'd0;
      sensor_freq_sel <= 3'd0;
      channel_gain_level <= 6'd0;
    end else begin
      sample_active <= (state_reg == ST_SEL && ch_on) || (state_reg == ST_SAMPLE && !win_done);
      sample_channel <= ch_reg;
      sensor_freq_sel <= cfg_reg.freq[ch_reg];
      channel_gain_level <= cfg_reg.gain[ch_reg];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      res_reg <= '0;
    end else if (win_done) begin
      res_reg[ch_reg] <= channel_result[ch_reg];
    end
  end

  // ----------------------------------------
  // Button decision
  // ----------------------------------------
  wire signed [RESULT_W-1:0] thr_pos = $signed(RESULT_W'(cfg_reg.threshold));
  wire signed [RESULT_W-1:0] thr_neg = -thr_pos;
  logic [NCH-1:0] over, under;
  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      over[k] = cfg_reg.enable[k] && $signed(res_reg[k]) >= thr_pos;
      under[k] = cfg_reg.enable[k] && $signed(res_reg[k]) < thr_neg;
    end
  end
  wire twist_hit = cfg_reg.twist && |under;
  wire [NCH-1:0] win_mask = max_pick(over & cfg_reg.maxwin, res_reg);
  wire [NCH-1:0] press_next = twist_hit ? '0 : (over & ~cfg_reg.maxwin) | win_mask;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      press_reg <= '0;
    end else if (state_reg == ST_DECIDE) begin
      press_reg <= press_next;
    end
  end

  // ----------------------------------------
  // Pins and post-processing controls
  // ----------------------------------------
  // Polarity bit 1 means active high; reset leaves every pin active low
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      button_output_pin <= '1;
      interrupt_pin <= 1'b1;
      baseline_pause <= '0;
      common_mode_en <= '0;
      deform_en <= '0;
    end else begin
      button_output_pin <= ~(press_reg ^ cfg_reg.out_pol);
      interrupt_pin <= ~((|press_reg || front_error) ^ cfg_reg.int_pol);
      baseline_pause <= cfg_reg.pause & press_reg;
      common_mode_en <= cfg_reg.common;
      deform_en <= cfg_reg.deform;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence scan_begin_s;
    state_reg == ST_WAIT && scan_tick;
  endsequence
  sequence window_open_s;
    state_reg == ST_SEL && ch_on;
  endsequence
  power_mode_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !power_mode_select_pin [*2] |-> low_power_reg)
    else $error("low power mode not taken");
  channel_skip_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_reg == ST_SEL && !ch_on |=> !sample_active)
    else $error("disabled channel sampled");
  // A scan may start right after the decision, so the polarity is the one that was applied
  out_polarity_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_reg == ST_DECIDE ##1 1'b1 |=>
      button_output_pin == ~($past(press_reg) ^ $past(cfg_reg.out_pol)))
    else $error("button pin polarity wrong");
  rate_select_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    scan_begin_s |=> cfg_reg.rate == ($past(low_power_reg) ? 3'($past(regs_reg[IX_LP_RATE]))
                                      : 3'($past(regs_reg[IX_NP_RATE]))))
    else $error("scan rate register not applied");
  window_len_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    window_open_s |=> win_cnt_reg == win_len(cfg_reg.cycles[ch_reg], cfg_reg.divider) - 1'b1)
    else $error("sampling window length wrong");
  gain_drive_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    window_open_s ##1 1'b1 |-> channel_gain_level == cfg_reg.gain[$past(ch_reg)])
    else $error("gain level not driven");
  threshold_reset_a: assert property (@(posedge core_clk)
    $rose(reset_n) |-> regs_reg[IX_THRESHOLD] == THRESHOLD_RESET)
    else $error("threshold reset value wrong");
  twist_block_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_reg == ST_DECIDE && twist_hit |=> press_reg == '0 ##1 baseline_pause == '0)
    else $error("twist did not suppress presses");
  interrupt_level_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    front_error && !cfg_reg.int_pol && $stable(cfg_reg) |=> !interrupt_pin)
    else $error("interrupt not asserted on error");
  shadow_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_reg != ST_WAIT |=> $stable(cfg_reg))
    else $error("configuration changed mid scan");
endmodule

// File: ibc_pkg.sv
// Constants, register map and types of the inductive button channel setup block
package ibc_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NCH = 4;
  localparam int NREG = 19;
  localparam int IXW = 5;
  localparam int SCAN_W = 28;
  localparam int WIN_W = 28;
  localparam int RATE_STEPS = 8;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SCAN_80SPS_US = 12500;
  localparam int SCAN_BASE_CYCLES_DEF = SCAN_80SPS_US * CLK_MHZ;
  localparam int WINDOW_UNIT = 128;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_ENABLE = 8'h0c;
  localparam logic [7:0] OFF_NP_RATE = 8'h0d;
  localparam logic [7:0] OFF_CHANNEL0_GAIN = 8'h0e;
  localparam logic [7:0] OFF_LP_RATE = 8'h0f;
  localparam logic [7:0] OFF_CHANNEL1_GAIN = 8'h10;
  localparam logic [7:0] OFF_INTERRUPT_POLARITY = 8'h11;
  localparam logic [7:0] OFF_CHANNEL2_GAIN = 8'h12;
  localparam logic [7:0] OFF_CHANNEL3_GAIN = 8'h14;
  localparam logic [7:0] OFF_PAUSE_WIN = 8'h16;
  localparam logic [7:0] OFF_DIVIDER = 8'h17;
  localparam logic [7:0] OFF_TWIST = 8'h19;
  localparam logic [7:0] OFF_COMMON_DEF = 8'h1a;
  localparam logic [7:0] OFF_OUT_POL = 8'h1c;
  localparam logic [7:0] OFF_SENS0 = 8'h20;
  localparam logic [7:0] OFF_SENS1 = 8'h22;
  localparam logic [7:0] OFF_SENS2 = 8'h24;
  localparam logic [7:0] OFF_SENS3 = 8'h26;
  localparam logic [7:0] OFF_THRESHOLD = 8'h30;
  localparam logic [7:0] OFF_STATUS = 8'h31;
  localparam logic [7:0] REG_OFF [NREG] = '{OFF_ENABLE, OFF_NP_RATE, OFF_CHANNEL0_GAIN,
    OFF_LP_RATE, OFF_CHANNEL1_GAIN, OFF_INTERRUPT_POLARITY, OFF_CHANNEL2_GAIN, OFF_CHANNEL3_GAIN, OFF_PAUSE_WIN,
    OFF_DIVIDER, OFF_TWIST, OFF_COMMON_DEF, OFF_OUT_POL, OFF_SENS0, OFF_SENS1,
    OFF_SENS2, OFF_SENS3, OFF_THRESHOLD, OFF_STATUS};

  // ----------------------------------------
  // Register indices and reset values
  // ----------------------------------------
  localparam int IX_ENABLE = 0;
  localparam int IX_NP_RATE = 1;
  localparam int IX_LP_RATE = 3;
  localparam int IX_INTERRUPT_POLARITY = 5;
  localparam int IX_PAUSE_WIN = 8;
  localparam int IX_DIVIDER = 9;
  localparam int IX_TWIST = 10;
  localparam int IX_COMMON_DEF = 11;
  localparam int IX_OUT_POL = 12;
  localparam int IX_SENS0 = 13;
  localparam int IX_THRESHOLD = 17;
  localparam int IX_STATUS = 18;
  localparam int GAIN_IX [NCH] = '{2, 4, 6, 7};
  localparam logic [7:0] THRESHOLD_RESET = 8'ha0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SENS_CYC_LSB = 0;
  localparam int SENS_FREQ_LSB = 5;
  localparam int HIGH_NIBBLE = 4;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {ST_WAIT, ST_SEL, ST_SAMPLE, ST_DECIDE} ibc_state_type;

  typedef struct packed {
    logic [NCH-1:0] enable;
    logic [2:0] rate;
    logic [NCH-1:0] pause;
    logic [NCH-1:0] maxwin;
    logic twist;
    logic [NCH-1:0] common;
    logic [NCH-1:0] deform;
    logic [NCH-1:0] out_pol;
    logic int_pol;
    logic [2:0] divider;
    logic [NCH-1:0][3:0] cycles;
    logic [NCH-1:0][2:0] freq;
    logic [NCH-1:0][5:0] gain;
    logic [7:0] threshold;
  } ibc_cfg_type;

endpackage

// File: ibc_front_model.sv
// Behavioural conversion front end feeding channel results to the setup block
`timescale 1ns/1ps
module ibc_front_model import ibc_pkg::*; (
  // Clock
  input wire logic core_clk,
  // Sequencing from the block
  input wire logic sample_active,
  input wire logic [1:0] sample_channel,
  // Levels commanded by the bench
  input wire logic [NCH-1:0][15:0] level_val,
  // Results to the block
  output logic [NCH-1:0][15:0] channel_result
);
  // ----------------------------------------
  // Result lines
  // ----------------------------------------
  logic [15:0] churn_reg = 16'h5a5a;

  // Outside its window a result is junk that moves every cycle, so a late capture shows
  always @(negedge core_clk) begin
    churn_reg <= {churn_reg[14:0], churn_reg[15] ^ churn_reg[13]};
  end

  always_comb begin
    for (int n = 0; n < NCH; n++) begin
      channel_result[n] = (sample_active && sample_channel == 2'(n)) ? level_val[n] : ~churn_reg;
    end
  end
endmodule

// File: tb_ibc_channel_setup.sv
// Self-checking testbench of the inductive button channel setup block
`timescale 1ns/1ps
module tb_ibc_channel_setup import ibc_pkg::*;;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic core_clk = 0;
  logic reset_n = 0;
  logic power_mode_select_pin = 1;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic front_error = 0;
  logic [NCH-1:0][15:0] level_val = '0;
  logic [NCH-1:0][15:0] channel_result;
  logic sample_active;
  logic [1:0] sample_channel;
  logic [2:0] sensor_freq_sel;
  logic [5:0] channel_gain_level;
  logic [NCH-1:0] baseline_pause, common_mode_en, deform_en, button_output_pin;
  logic interrupt_pin;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h94a3;

  always #5 core_clk = ~core_clk;

  ibc_channel_setup #(.SCAN_BASE_CYCLES(64), .SENSOR_TICK_CYCLES(1), .RESULT_W(16)) u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .power_mode_select_pin(power_mode_select_pin),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .channel_result(channel_result),
    .front_error(front_error), .sample_active(sample_active), .sample_channel(sample_channel),
    .sensor_freq_sel(sensor_freq_sel), .channel_gain_level(channel_gain_level),
    .baseline_pause(baseline_pause), .common_mode_en(common_mode_en), .deform_en(deform_en),
    .button_output_pin(button_output_pin), .interrupt_pin(interrupt_pin));

  ibc_front_model u_front (.core_clk(core_clk), .sample_active(sample_active),
    .sample_channel(sample_channel), .level_val(level_val), .channel_result(channel_result));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Host side divider choice, clamped at zero
  function automatic logic [2:0] div_calc(input int f_mhz, input int t_us);
    int p;
    p = $clog2(f_mhz * t_us) - 12;
    return (p < 0) ? 3'h0 : 3'(p);
  endfunction

  function automatic int win_len(input int cyc, input int dv);
    return (128 * (cyc + 1)) << dv;
  endfunction

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge core_clk);
    chk(reg_rvalid === 1'b1 && reg_rdata === e, "read back");
    reg_rd = 0;
  endtask

  // Waits out the current high phase and the following low phase
  task automatic next_rise(output int hi, output int tot);
    hi = 0;
    tot = 0;
    while (sample_active === 1'b1 && tot < 30000) begin
      @(negedge core_clk);
      hi++;
      tot++;
    end
    while (sample_active !== 1'b1 && tot < 30000) begin
      @(negedge core_clk);
      tot++;
    end
  endtask

  task automatic wait_out(input logic [3:0] ep, input logic ei, input string msg);
    int n;
    n = 0;
    while (!(button_output_pin === ep && interrupt_pin === ei) && n < 30000) begin
      @(negedge core_clk);
      n++;
    end
    chk(n < 30000, msg);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge core_clk);
    err_total++;
    conclude();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    int hi, tot;
    logic [7:0] d;
    repeat (5) @(negedge core_clk);
    reset_n = 1;
    front_error = 1;
    repeat (2) @(negedge core_clk);
    chk(interrupt_pin === 1'b0, "error interrupt low");
    front_error = 0;
    for (int i = 0; i < NREG - 1; i++) rd(REG_OFF[i], (i == IX_THRESHOLD) ? 8'ha0 : 8'h00);
    // Channels stay disabled so no long random window starts
    for (int i = 0; i < IX_THRESHOLD; i++) begin
      seed = lfsr_next(seed);
      d = (i == IX_ENABLE) ? (seed[7:0] & 8'hf0) : seed[7:0];
      wr(REG_OFF[i], d);
      rd(REG_OFF[i], d);
    end
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h00);
    for (int i = 0; i < IX_THRESHOLD; i++) wr(REG_OFF[i], 8'h00);
    $display("test registers done");
    d = {5'h00, div_calc(4, 2048)};
    wr(OFF_DIVIDER, d);
    wr(OFF_SENS0, 8'ha1);
    wr(OFF_CHANNEL0_GAIN, 8'h21);
    wr(OFF_ENABLE, 8'h01);
    next_rise(hi, tot);
    chk(sample_channel === 2'h0 && sensor_freq_sel === 3'h5, "freq select");
    chk(channel_gain_level === 6'h21, "gain level");
    next_rise(hi, tot);
    chk(hi == win_len(1, int'(d)), "window length");
    $display("test window done");
    level_val[0] = 16'h00c8;
    wait_out(4'he, 1'b0, "press active low");
    wr(OFF_OUT_POL, 8'h01);
    wr(OFF_INTERRUPT_POLARITY, 8'h01);
    wait_out(4'hf, 1'b1, "press active high");
    level_val[0] = 16'h0064;
    wait_out(4'he, 1'b0, "release");
    front_error = 1;
    repeat (2) @(negedge core_clk);
    chk(interrupt_pin === 1'b1, "error interrupt");
    front_error = 0;
    $display("test press done");
    wr(OFF_OUT_POL, 8'h00);
    wr(OFF_INTERRUPT_POLARITY, 8'h00);
    wr(OFF_SENS0, 8'h00);
    wr(OFF_DIVIDER, 8'h00);
    wr(OFF_SENS1, 8'he0);
    wr(OFF_COMMON_DEF, 8'h5a);
    wr(OFF_PAUSE_WIN, 8'h32);
    level_val[0] = 16'h00c8;
    level_val[1] = 16'h012c;
    wr(OFF_ENABLE, 8'h07);
    wait_out(4'hd, 1'b0, "largest wins");
    @(negedge core_clk);
    chk(baseline_pause === 4'h2 && common_mode_en === 4'ha && deform_en === 4'h5, "feat");
    for (int k = 0; k < 30000 && !(sample_active === 1'b1 && sample_channel === 2'h1); k++) begin
      @(negedge core_clk);
    end
    chk(sensor_freq_sel === 3'h7, "second channel freq");
    level_val[2] = 16'hff38;
    wr(OFF_TWIST, 8'h01);
    wait_out(4'hf, 1'b1, "twist clears");
    $display("test features done");
    level_val = '0;
    wr(OFF_ENABLE, 8'h01);
    for (int r = 3; r < RATE_STEPS; r++) begin
      wr(OFF_NP_RATE, 8'(r));
      next_rise(hi, tot);
      next_rise(hi, tot);
      next_rise(hi, tot);
      chk(tot == (64 << r), "scan period");
    end
    power_mode_select_pin = 0;
    wr(OFF_LP_RATE, 8'h03);
    next_rise(hi, tot);
    next_rise(hi, tot);
    next_rise(hi, tot);
    chk(tot == 512, "low power period");
    $display("test rates done");
    conclude();
  end
endmodule
